// ---- core/pit_irq_pkg.sv ----
// Constants shared by the periodic timer and request recognition block.
// Assumes a single 125 MHz system clock and a plain strobe register port.
package pit_irq_pkg;
  localparam int unsigned CLOCK_HZ         = 125_000_000;
  localparam logic [3:0]  ADDR_CONTROL     = 4'h0;
  localparam logic [3:0]  ADDR_MODULUS     = 4'h1;
  localparam logic [3:0]  ADDR_MASK        = 4'h2;
  localparam logic [3:0]  ADDR_STATUS      = 4'h3;
  localparam int unsigned VEC_LSB          = 0;
  localparam int unsigned LVL_LSB          = 8;
  localparam int unsigned TM_LSB           = 0;
  localparam int unsigned PS_BIT           = 8;
  localparam logic [7:0]  VECTOR_RESET     = 8'h0f;
  localparam logic [2:0]  LEVEL_RESET      = 3'h0;
  localparam logic [7:0]  MODULUS_RESET    = 8'h00;
  localparam logic [2:0]  MASK_RESET       = 3'h7;
  localparam logic [2:0]  LEVEL_OFF        = 3'h0;
  localparam logic [2:0]  LEVEL_NMI        = 3'h7;
  localparam int unsigned PRESCALE_DIV     = 512;
  localparam int unsigned BASE_DIV         = 4;
  localparam int unsigned VALID_SAMPLES    = 2;
  localparam logic [10:0] CONTROL_MASK     = 11'h7ff;
endpackage

// ---- core/pit_irq.sv ----
// Periodic interrupt timer with processor request recognition logic.
// Assumes crystal_input is a slow reference from a pin; request pins are async.
// Function
// RL1 - Level code 111 gives level seven
// RL2 - Code 000 disables; 001-110 levels one-six
// RL3 - Acknowledge of timer drives its vector
// RL4 - Zero modulus stops the timer
// RL5 - Modulus register accessible at any time
// RL6 - Prescale select: bypass or divide 512
// RL7 - Prescale bit resets to inverted strap
// RL8 - Period is modulus times prescale times four
// RL9 - Count quarter reference, pulse, reload modulus
// RL10 - Timer keeps counting while request disabled
// RL11 - Timer wins over same-level external request
// RL12 - Eight levels, below seven maskable
// RL13 - Seven lines, line one lowest
// RL14 - Mask blocks level at or below it
// RL15 - Servicing loads mask with serviced level
// RL16 - Internal requests never drive the pins
// RL17 - External requests appear as module requests
// RL18 - Lines one-six active low level sensitive
// RL19 - Level seven needs edge then held low
// RL20 - Seven re-fires when mask drops from 111
// RL21 - Two consecutive low samples make valid
// RL22 - Taken only at instruction boundary
// RL23 - Pending level is not latched
// RL24 - Masked requests leave no trace
// RL25 - Present highest unmasked level, seven overrides
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pit_irq #(
  parameter int unsigned PRESCALE = pit_irq_pkg::PRESCALE_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        clock_mode_strap,
  input  wire logic        crystal_input,
  input  wire logic [7:1]  irq_pin_n,
  input  wire logic [7:1]  module_irq,
  input  wire logic        boundary,
  input  wire logic        ack_strobe,
  output logic      [2:0]  pending_level,
  output logic             pending_valid,
  output logic             ack_from_timer,
  output logic      [7:0]  ack_vector,
  output logic             timer_tick
);
  import pit_irq_pkg::*;

  logic [7:0] periodic_vector;
  logic [2:0] periodic_request_level;
  logic [7:0] timing_modulus;
  logic       prescale_select;
  logic [2:0] priority_mask;
  logic [2:0] strap_sync;
  logic [2:0] xtal_sync;
  logic [8:0] prescale_count;
  logic [1:0] quarter_count;
  logic [7:0] timer_count;
  logic       timer_request;
  logic [7:1] pin_meta;
  logic [7:1] pin_sync;
  logic [7:1] pin_prev;
  logic [7:1] line_valid;
  logic       nmi_prev_valid;
  logic       nmi_pending;
  logic [2:0] mask_prev;

  // Settings register writes; the prescale bit follows the inverted strap while reset is held.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      periodic_vector        <= VECTOR_RESET;
      periodic_request_level <= LEVEL_RESET;
      timing_modulus         <= MODULUS_RESET;
      // The strap synchroniser runs through reset, so its last value is the strap level.
      prescale_select        <= ~strap_sync[1]; // RL7
    end else begin
      if (reg_write && reg_addr == ADDR_CONTROL) begin
        periodic_vector        <= reg_wdata[VEC_LSB +: 8];
        periodic_request_level <= reg_wdata[LVL_LSB +: 3];
      end else if (reg_write && reg_addr == ADDR_MODULUS) begin
        timing_modulus  <= reg_wdata[TM_LSB +: 8]; // RL5
        prescale_select <= reg_wdata[PS_BIT];
      end
    end
  end

  // The strap must be sampled during reset, so its synchroniser has no reset.
  always_ff @(posedge clock) begin
    strap_sync <= {strap_sync[1:0], clock_mode_strap};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xtal_sync <= 3'h0;
    end else begin
      xtal_sync <= {xtal_sync[1:0], crystal_input};
    end
  end

  logic xtal_rise;
  logic ps_tick;
  logic quarter_tick;
  assign xtal_rise    = xtal_sync[1] & ~xtal_sync[2];
  assign ps_tick      = xtal_rise &&
                        (!prescale_select || prescale_count == 9'(PRESCALE - 1)); // RL6
  assign quarter_tick = ps_tick && quarter_count == 2'(BASE_DIV - 1); // RL8

  // Timer counts down from the modulus; a zero modulus halts everything.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prescale_count <= 9'h000;
      quarter_count  <= 2'h0;
      timer_count    <= 8'h00;
      timer_tick     <= 1'b0;
    end else begin
      timer_tick <= 1'b0;
      if (timing_modulus == 8'h00) begin // RL4
        prescale_count <= 9'h000;
        quarter_count  <= 2'h0;
        timer_count    <= 8'h00;
      end else begin
        if (xtal_rise) begin
          prescale_count <= ps_tick ? 9'h000 : prescale_count + 9'h001;
        end
        if (ps_tick) begin
          quarter_count <= quarter_count + 2'h1;
        end
        if (quarter_tick) begin
          if (timer_count <= 8'h01) begin
            timer_count <= timing_modulus; // RL9
            timer_tick  <= 1'b1;           // RL10
          end else begin
            timer_count <= timer_count - 8'h01;
          end
        end
      end
    end
  end

  // Timer request stays until acknowledged or the level is set to 000; a new tick wins over the clear.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_request <= 1'b0;
    end else if (timer_tick && periodic_request_level != LEVEL_OFF) begin // RL2
      timer_request <= 1'b1;
    end else if (ack_strobe && ack_from_timer) begin
      timer_request <= 1'b0;
    end else if (periodic_request_level == LEVEL_OFF) begin
      timer_request <= 1'b0;
    end
  end

  // Pins are sampled on falling edges, as the request lines are specified.
  always_ff @(negedge clock) begin
    if (!rst_n) begin
      pin_meta <= 7'h7f;
      pin_sync <= 7'h7f;
      pin_prev <= 7'h7f;
    end else begin
      pin_meta <= irq_pin_n;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync; // RL21
    end
  end

  // Pin levels only feed the recognition logic; nothing drives them back.
  logic [7:1] line_req;
  logic [7:1] timer_line;
  genvar g;
  generate
    for (g = 1; g <= 7; g++) begin : g_line
      assign timer_line[g] = timer_request && periodic_request_level == 3'(g); // RL1
      assign line_valid[g] = ~pin_sync[g] & ~pin_prev[g]; // RL18
      assign line_req[g]   = line_valid[g] | module_irq[g] | timer_line[g]; // RL16 RL17
    end
  endgenerate

  function automatic logic [2:0] top_level(input logic [7:1] req, input logic [2:0] mask);
    logic [2:0] lvl;
    lvl = 3'h0;
    for (int i = 1; i <= 6; i++) begin
      if (req[i] && 3'(i) > mask) begin // RL14
        lvl = 3'(i); // RL13
      end
    end
    return lvl;
  endfunction

  // Level seven: edge plus held level, and re-armed when the mask drops.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nmi_prev_valid <= 1'b0;
      nmi_pending    <= 1'b0;
      mask_prev      <= MASK_RESET;
    end else begin
      nmi_prev_valid <= line_req[7];
      mask_prev      <= priority_mask;
      if ((line_req[7] && !nmi_prev_valid) || // RL19
          (line_req[7] && mask_prev == LEVEL_NMI && priority_mask != LEVEL_NMI)) begin // RL20
        nmi_pending <= 1'b1;
      end else if (ack_strobe && pending_level == LEVEL_NMI) begin
        nmi_pending <= 1'b0;
      end
    end
  end

  logic [2:0] live_level;
  assign live_level    = nmi_pending ? LEVEL_NMI : top_level(line_req, priority_mask); // RL25
  assign pending_level = live_level; // RL23 RL24
  assign pending_valid = (live_level != 3'h0) && boundary; // RL22 RL12
  assign ack_from_timer = timer_request && periodic_request_level == live_level; // RL11

  // Exception entry raises the mask to the serviced level.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      priority_mask <= MASK_RESET;
      ack_vector    <= 8'h00;
    end else begin
      if (ack_strobe && pending_valid) begin
        priority_mask <= live_level; // RL15
        ack_vector    <= ack_from_timer ? periodic_vector : 8'h00; // RL3
      end else if (reg_write && reg_addr == ADDR_MASK) begin
        priority_mask <= reg_wdata[2:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_read) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == ADDR_CONTROL) begin
      reg_rdata <= {5'h00, 11'({periodic_request_level, periodic_vector}) & CONTROL_MASK};
    end else if (reg_addr == ADDR_MODULUS) begin
      reg_rdata <= {7'h00, prescale_select, timing_modulus};
    end else if (reg_addr == ADDR_MASK) begin
      reg_rdata <= {13'h0000, priority_mask};
    end else if (reg_addr == ADDR_STATUS) begin
      reg_rdata <= {timer_count, nmi_pending, timer_request, 3'h0, live_level};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

// ---- tb/irq_sources.sv ----
// Model of the external interrupting devices and on-chip requesters.
// Assumes the bench commands each request line through dev_req and mod_req.
`timescale 1ns/1ps
module irq_sources (
  input  wire logic       clock,
  input  wire logic [7:1] dev_req,
  input  wire logic [7:1] mod_req,
  output logic      [7:1] irq_pin_n,
  output logic      [7:1] module_irq
);
  // The pins are open drain with pull-ups, so a released line reads high.
  initial irq_pin_n = 7'h7f;
  initial module_irq = 7'h00;
  always @(posedge clock) begin
    irq_pin_n  <= ~dev_req;
    module_irq <= mod_req;
  end
endmodule

// ---- tb/pit_irq_checker.sv ----
// Port-level assertions for the periodic timer and request recognition.
// Assumes the single system clock and the synchronous active-low reset.
`timescale 1ns/1ps
module pit_irq_checker
  import pit_irq_pkg::*;
#(
  parameter int unsigned PRESCALE = 512
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        boundary,
  input wire logic        ack_strobe,
  input wire logic [2:0]  pending_level,
  input wire logic        pending_valid,
  input wire logic        ack_from_timer,
  input wire logic [7:0]  ack_vector,
  input wire logic        timer_tick
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property ($past(reg_read) && $past(reg_addr) > 4'h3
    |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  ctrl_resvd_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_CONTROL
    |-> reg_rdata[15:11] == 5'h00) else $error("control upper bits not zero");
  mod_resvd_a: assert property ($past(reg_read) && $past(reg_addr) == ADDR_MODULUS
    |-> reg_rdata[15:9] == 7'h00) else $error("modulus upper bits not zero");
  valid_gate_a: assert property (pending_valid == (pending_level != 3'h0 && boundary))
    else $error("pending valid not gated by boundary");
  tick_space_a: assert property (timer_tick |=> !timer_tick [*8])
    else $error("timer ticks too close");
  ext_vector_a: assert property (ack_strobe && pending_valid && !ack_from_timer
    |=> ack_vector == 8'h00) else $error("vector driven for a non-timer request");
  ack_mask_a: assert property (ack_strobe && pending_valid && pending_level != 3'h7
    |=> pending_level == 3'h0 || pending_level > $past(pending_level) || pending_level == 3'h7)
    else $error("serviced level still presented after acknowledge");
  timer_level_a: assert property (ack_from_timer |-> pending_level != 3'h0)
    else $error("timer claims an acknowledge with nothing pending");
endmodule
bind pit_irq pit_irq_checker #(.PRESCALE(PRESCALE)) chk (.clock, .rst_n, .reg_addr,
  .reg_read, .reg_rdata, .boundary, .ack_strobe, .pending_level, .pending_valid,
  .ack_from_timer, .ack_vector, .timer_tick);

// ---- tb/tb_top.sv ----
// Self-checking bench for the periodic timer and request recognition block.
// Assumes the design package is compiled first and the strap is held high.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import pit_irq_pkg::*;
  localparam int PS = 2;
  logic clock = 0, rst_n = 0, reg_write = 0, reg_read = 0, boundary = 0, ack_strobe = 0;
  logic clock_mode_strap = 1, crystal_input = 0, pending_valid, ack_from_timer, timer_tick;
  logic [3:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, v;
  logic [7:1] dev_req = 0, mod_req = 0, irq_pin_n, module_irq;
  logic [2:0] pending_level;
  logic [7:0] ack_vector;
  int failures = 0, num_checks = 0, cyc = 0, n;
  always #4 clock = ~clock;
  // The reference is ten system cycles long, so tick gaps come out exact.
  always #40 crystal_input = ~crystal_input;
  irq_sources devs (.clock, .dev_req, .mod_req, .irq_pin_n, .module_irq);
  pit_irq #(.PRESCALE(PS)) dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .clock_mode_strap, .crystal_input, .irq_pin_n, .module_irq,
    .boundary, .ack_strobe, .pending_level, .pending_valid, .ack_from_timer,
    .ack_vector, .timer_tick);
  task wt(input int c); repeat (c) @(posedge clock); endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
    @(posedge clock); reg_write <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a; reg_read <= 1'b1;
    @(posedge clock); reg_read <= 1'b0;
    @(posedge clock); d = reg_rdata;
  endtask
  task ack();
    boundary <= 1'b1; ack_strobe <= 1'b1;
    @(posedge clock); ack_strobe <= 1'b0; boundary <= 1'b0;
    @(posedge clock);
  endtask
  task gap();
    n = 0;
    while (timer_tick !== 1'b1 && n < 400) begin @(posedge clock); n++; end
    n = 0;
    do begin @(posedge clock); n++; end while (timer_tick !== 1'b1 && n < 400);
  endtask
  task t_regs();
    rd(ADDR_MODULUS, v); `CHK("modulus reset", 16'h0000, v)
    rd(ADDR_CONTROL, v); `CHK("control reset", 16'h000f, v)
    wr(ADDR_CONTROL, 16'hffff); wr(ADDR_MODULUS, 16'hffff);
    rd(ADDR_CONTROL, v); `CHK("control bits", 16'h07ff, v)
    rd(ADDR_MODULUS, v); `CHK("modulus bits", 16'h01ff, v)
    rd(4'h9, v); `CHK("unmapped", 16'h0000, v)
    wr(ADDR_CONTROL, 16'h0000); wr(ADDR_MODULUS, 16'h0001);
    $display("test regs done");
  endtask
  task t_timer();
    for (int l = 0; l < 8; l++) begin
      wr(ADDR_MASK, 16'h0000);
      wr(ADDR_CONTROL, {5'h00, 3'(l), 5'h0a, 3'(l)});
      dev_req[3] <= (l == 3);
      gap(); `CHK("tick seen", 1'b1, n < 400)
      wt(2); `CHK("timer level", 3'(l), pending_level)
      if (l == 3) `CHK("timer first", 1'b1, ack_from_timer)
      if (l != 0) begin
        ack(); `CHK("timer vector", {5'h0a, 3'(l)}, ack_vector)
      end
    end
    dev_req <= 7'h00;
    $display("test timer done");
  endtask
  task t_period();
    wr(ADDR_CONTROL, 16'h0000); ack();
    wr(ADDR_MODULUS, 16'h0101); gap(); `CHK("prescaled gap", 1 * PS * 4 * 10, n)
    wr(ADDR_MODULUS, 16'h0001); gap(); `CHK("plain gap", 40, n)
    wr(ADDR_MODULUS, 16'h0000); wt(4); n = 0;
    repeat (300) begin @(posedge clock); if (timer_tick === 1'b1) n++; end
    `CHK("stopped ticks", 0, n)
    $display("test period done");
  endtask
  task t_ext();
    wr(ADDR_MASK, 16'h0000); dev_req <= 7'h04; @(posedge clock); dev_req <= 7'h00;
    wt(8); `CHK("short pulse", 3'h0, pending_level)
    wr(ADDR_MASK, 16'h0007); dev_req <= 7'h10;
    wt(8); `CHK("masked five", 3'h0, pending_level)
    dev_req <= 7'h00; wt(8); wr(ADDR_MASK, 16'h0000);
    wt(2); `CHK("no trace", 3'h0, pending_level)
    dev_req <= 7'h12;
    wt(8); `CHK("highest line", 3'h5, pending_level)
    wr(ADDR_MASK, 16'h0005);
    wt(1); `CHK("mask equal", 3'h0, pending_level)
    dev_req <= 7'h52;
    wt(8); `CHK("level seven", 3'h7, pending_level)
    ack(); `CHK("seven held", 3'h0, pending_level)
    wr(ADDR_MASK, 16'h0000);
    wt(2); `CHK("mask drop", 3'h7, pending_level)
    ack(); dev_req <= 7'h00; wt(8); mod_req <= 7'h20; wr(ADDR_MASK, 16'h0000);
    wt(4); `CHK("module six", 3'h6, pending_level)
    mod_req <= 7'h00;
    $display("test ext done");
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin failures++; tally_and_finish(); end
  end
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    wt(4);
    t_regs(); t_timer(); t_period(); t_ext();
    tally_and_finish();
  end
endmodule
